/* hw/mptc_pkg.sv */
// package: register map, fields, reset values and modes of the pwm time base control
package mptc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_TB_CTRL   = 4'h0;
  localparam logic [3:0] OFS_TB_COUNT  = 4'h1;
  localparam logic [3:0] OFS_TB_PERIOD = 4'h2;
  localparam logic [3:0] OFS_SEV_CMP   = 4'h3;
  localparam logic [3:0] OFS_PIN_CTRL  = 4'h4;
  localparam logic [3:0] OFS_UPD_CTRL  = 4'h5;
  localparam logic [3:0] OFS_DUTY_BUF  = 4'h6;
  localparam logic [3:0] OFS_DUTY_ACT  = 4'h7;
  localparam logic [3:0] OFS_OVR_BUF   = 4'h8;
  localparam logic [3:0] OFS_OVR_ACT   = 4'h9;
  localparam logic [3:0] OFS_PER_ACT   = 4'ha;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TB_EN_BIT       = 15;
  localparam int TB_IDLE_BIT     = 13;
  localparam int TB_OPS_LSB      = 4;
  localparam int TB_CKPS_LSB     = 2;
  localparam int TB_MODE_LSB     = 0;
  localparam int DIR_BIT         = 15;
  localparam int PMOD_LSB        = 8;
  localparam int PENH_LSB        = 4;
  localparam int PENL_LSB        = 0;
  localparam int SEVOPS_LSB      = 8;
  localparam int IUE_BIT         = 2;
  localparam int OVERRIDE_SYNC_SEL_BIT       = 1;
  localparam int BUFFER_UPDATE_LOCKOUT_BIT        = 0;

  // ---------------------------------------------------------------
  // reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [15:0] TB_CTRL_RST  = 16'h0000;
  localparam logic [15:0] TB_CTRL_MASK = 16'ha0ff;
  localparam logic [15:0] UPD_CTRL_MASK = 16'h0f07;
  localparam logic [15:0] PIN_CTRL_MASK = 16'h0fff;
  localparam logic [14:0] CNT_RST      = 15'h0000;
  localparam logic [15:0] ZERO16       = 16'h0000;
  localparam logic [7:0]  PEN_ALL_ON   = 8'hff;
  localparam logic [7:0]  PEN_ALL_OFF  = 8'h00;

  // prescale divide counts: 1, 4, 16, 64 instruction cycles
  localparam logic [5:0] PRE_DIV1  = 6'h00;
  localparam logic [5:0] PRE_DIV4  = 6'h03;
  localparam logic [5:0] PRE_DIV16 = 6'h0f;
  localparam logic [5:0] PRE_DIV64 = 6'h3f;

  // time base modes
  typedef enum logic [1:0] {
    MPTC_FREE   = 2'h0,
    MPTC_SINGLE = 2'h1,
    MPTC_UPDN   = 2'h2,
    MPTC_UPDN2  = 2'h3
  } mptc_mode_t;

endpackage

/* hw/mptc_postscale.sv */
// module: event postscaler passing one pulse per ratio+1 input events
`timescale 1ns/1ps
module mptc_postscale (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       clr,
  input  wire logic [3:0] ratio,
  input  wire logic       evt_in,
  output logic            evt_out
);

  logic [3:0] cnt_q;

  // ---------------------------------------------------------------
  // event counter
  // ---------------------------------------------------------------
  // counts events, wraps at ratio, emits on the wrap
  always_ff @(posedge sys_clk) begin
    if (srst || clr) begin
      cnt_q <= 4'h0;
    end else if (evt_in) begin
      if (cnt_q >= ratio) begin
        cnt_q <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // output pulse combinational with the event
  assign evt_out = evt_in && !srst && !clr && (cnt_q >= ratio);

endmodule

/* hw/mptc_top.sv */
// module: pwm time base, special event trigger, pin and update control
// Function
// RULE1: either fault pin may wake the processor from sleep
// RULE2: in sleep a low fault pin raises the fault interrupt
// RULE3: idle-stop bit set halts time base while processor idles
// RULE4: counter runs only while time base enable bit is set
// RULE5: output postscale field gives event ratio of value plus one
// RULE6: input prescale codes give count periods of 1, 4, 16, 64 cycles
// RULE7: mode field picks free-run, single pulse, up/down, up/down double
// RULE8: count register bit 15 is read-only direction, 1 means down
// RULE9: count register bits 14-0 hold readable, writable count
// RULE10: period register holds 15-bit period, bit 15 reads zero
// RULE11: trigger fires only when direction matches selected direction bit; code checks the direction in up/down modes only
// RULE12: compare value matching count makes the converter trigger
// RULE13: pair mode bit set gives independent, clear complementary
// RULE14: high enable bits route pwm to high pins, else gpio
// RULE15: low enable bits route pwm to low pins, else gpio
// RULE16: pin enable reset value comes from nonvolatile configuration
// RULE17: trigger postscale field passes one trigger per N matches
// RULE18: immediate bit makes duty writes active at once
// RULE19: override sync bit applies overrides in step with time base
// RULE20: update disable bit blocks buffer to active transfers; code still lets immediate duty writes and override transfers through
// RULE21: synced overrides at zero, and at period in centre modes
// RULE22: trigger postscaler cleared by compare write and reset
// RULE23: period updates follow only the update disable bit
// RULE24: free-run counts zero to period; up/down reverses at ends
`timescale 1ns/1ps
module mptc_top (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  input  wire logic        pin_reset_config,
  input  wire logic        cpu_sleep,
  input  wire logic        cpu_idle,
  input  wire logic        fault_a_n,
  input  wire logic        fault_b_n,
  output logic             fault_wake,
  output logic             fault_irq,
  output logic             tb_event,
  output logic             trigger_out,
  output logic [3:0]       pair_mode_sel,
  output logic [3:0]       high_pin_enables,
  output logic [3:0]       low_pin_enables,
  output logic [15:0]      duty_active,
  output logic [15:0]      override_active,
  output logic [14:0]      period_active
);

  logic [15:0] tb_ctrl_q;
  logic [14:0] cnt_q;
  logic        dir_q;
  logic [14:0] per_buf_q;
  logic [14:0] per_act_q;
  logic        sev_dir_q;
  logic [14:0] sev_cmp_q;
  logic [3:0]  pmod_q;
  logic [7:0]  pen_q;
  logic [15:0] upd_ctrl_q;
  logic [15:0] duty_buf_q;
  logic [15:0] duty_act_q;
  logic [15:0] ovr_buf_q;
  logic [15:0] ovr_act_q;
  logic [5:0]  pre_q;
  logic [5:0]  pre_lim;
  logic        tb_run;
  logic        tick;
  logic        at_zero;
  logic        at_per;
  logic        period_evt;
  logic        bound;
  logic        sev_match;
  logic        sev_wr;
  logic        cnt_wr;
  logic        buffer_update_lockout;
  logic        centre;
  logic [15:0] rdata_d;
  logic        faults_low;
  logic        first_q;
  mptc_pkg::mptc_mode_t mode;

  assign mode    = mptc_pkg::mptc_mode_t'(tb_ctrl_q[mptc_pkg::TB_MODE_LSB +: 2]);
  assign centre  = (mode == mptc_pkg::MPTC_UPDN) || (mode == mptc_pkg::MPTC_UPDN2);
  assign buffer_update_lockout    = upd_ctrl_q[mptc_pkg::BUFFER_UPDATE_LOCKOUT_BIT];
  assign sev_wr  = reg_wr && (reg_addr == mptc_pkg::OFS_SEV_CMP);
  assign cnt_wr  = reg_wr && (reg_addr == mptc_pkg::OFS_TB_COUNT);

  // ---------------------------------------------------------------
  // sleep wake and fault interrupt
  // ---------------------------------------------------------------
  // either low fault pin wakes and interrupts while asleep
  assign faults_low = !fault_a_n || !fault_b_n;
  assign fault_wake = cpu_sleep && faults_low; // RULE1
  assign fault_irq  = cpu_sleep && faults_low; // RULE2

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  // time base control, writable bits only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tb_ctrl_q <= mptc_pkg::TB_CTRL_RST;
    end else if (reg_wr && reg_addr == mptc_pkg::OFS_TB_CTRL) begin
      tb_ctrl_q <= reg_wdata & mptc_pkg::TB_CTRL_MASK;
    end
  end

  // update control and trigger postscale
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      upd_ctrl_q <= mptc_pkg::ZERO16;
    end else if (reg_wr && reg_addr == mptc_pkg::OFS_UPD_CTRL) begin
      upd_ctrl_q <= reg_wdata & mptc_pkg::UPD_CTRL_MASK;
    end
  end

  // pin control; enables reload from configuration strap after reset
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pmod_q  <= 4'h0;
      pen_q   <= mptc_pkg::PEN_ALL_OFF;
      first_q <= 1'b1;
    end else if (first_q) begin
      first_q <= 1'b0;
      pen_q   <= pin_reset_config ? mptc_pkg::PEN_ALL_ON : mptc_pkg::PEN_ALL_OFF; // RULE16
    end else if (reg_wr && reg_addr == mptc_pkg::OFS_PIN_CTRL) begin
      pmod_q <= reg_wdata[mptc_pkg::PMOD_LSB +: 4];
      pen_q  <= reg_wdata[7:0];
    end
  end

  assign pair_mode_sel    = pmod_q; // RULE13
  assign high_pin_enables = pen_q[mptc_pkg::PENH_LSB +: 4]; // RULE14
  assign low_pin_enables  = pen_q[mptc_pkg::PENL_LSB +: 4]; // RULE15

  // special event compare and direction
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sev_dir_q <= 1'b0;
      sev_cmp_q <= mptc_pkg::CNT_RST;
    end else if (sev_wr) begin
      sev_dir_q <= reg_wdata[mptc_pkg::DIR_BIT];
      sev_cmp_q <= reg_wdata[14:0];
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  // divider limit per prescale code
  always_comb begin
    unique case (tb_ctrl_q[mptc_pkg::TB_CKPS_LSB +: 2])
      2'h0: pre_lim = mptc_pkg::PRE_DIV1;
      2'h1: pre_lim = mptc_pkg::PRE_DIV4;
      2'h2: pre_lim = mptc_pkg::PRE_DIV16;
      2'h3: pre_lim = mptc_pkg::PRE_DIV64;
    endcase
  end

  // time base runs when enabled and not stopped by idle
  assign tb_run = tb_ctrl_q[mptc_pkg::TB_EN_BIT] &&
                  !(cpu_idle && tb_ctrl_q[mptc_pkg::TB_IDLE_BIT]); // RULE3 RULE4
  assign tick   = tb_run && (pre_q >= pre_lim); // RULE6

  // prescale counter
  always_ff @(posedge sys_clk) begin
    if (srst || !tb_ctrl_q[mptc_pkg::TB_EN_BIT]) begin
      pre_q <= 6'h00;
    end else if (tb_run) begin
      pre_q <= tick ? 6'h00 : pre_q + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // counter and direction
  // ---------------------------------------------------------------
  assign at_zero = (cnt_q == mptc_pkg::CNT_RST);
  assign at_per  = (cnt_q >= per_act_q);

  // count up to period, then wrap, hold or reverse per mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= mptc_pkg::CNT_RST;
      dir_q <= 1'b0;
    end else if (cnt_wr) begin
      cnt_q <= reg_wdata[14:0]; // RULE9
    end else if (tick) begin // RULE4
      unique case (mode) // RULE7
        mptc_pkg::MPTC_FREE: begin
          dir_q <= 1'b0; // RULE8
          cnt_q <= at_per ? mptc_pkg::CNT_RST : cnt_q + 15'h0001; // RULE24
        end
        mptc_pkg::MPTC_SINGLE: begin
          dir_q <= 1'b0; // RULE8
          if (!at_per) begin
            cnt_q <= cnt_q + 15'h0001;
          end
        end
        mptc_pkg::MPTC_UPDN, mptc_pkg::MPTC_UPDN2: begin
          if (!dir_q && at_per) begin
            dir_q <= 1'b1; // RULE24
            cnt_q <= cnt_q - 15'h0001;
          end else if (dir_q && at_zero) begin
            dir_q <= 1'b0;
            cnt_q <= cnt_q + 15'h0001;
          end else begin
            cnt_q <= dir_q ? cnt_q - 15'h0001 : cnt_q + 15'h0001;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // period and update transfers
  // ---------------------------------------------------------------
  // period event: wrap in free run, each end in double-update mode
  assign period_evt = tick && (centre ? ((mode == mptc_pkg::MPTC_UPDN2) ? (at_zero || (!dir_q && at_per))
                                                                         : (dir_q && at_zero))
                                      : at_per);
  // override sync boundary: zero, plus period in centre modes
  assign bound = tick && (at_zero || (centre && at_per)); // RULE21

  // period buffer and active period
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      per_buf_q <= mptc_pkg::CNT_RST;
      per_act_q <= mptc_pkg::CNT_RST;
    end else begin
      if (reg_wr && reg_addr == mptc_pkg::OFS_TB_PERIOD) begin
        per_buf_q <= reg_wdata[14:0]; // RULE10
      end
      if (!buffer_update_lockout && (period_evt || !tb_run)) begin
        per_act_q <= per_buf_q; // RULE20 RULE23
      end
    end
  end

  // duty buffer and active duty
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      duty_buf_q <= mptc_pkg::ZERO16;
      duty_act_q <= mptc_pkg::ZERO16;
    end else begin
      if (reg_wr && reg_addr == mptc_pkg::OFS_DUTY_BUF) begin
        duty_buf_q <= reg_wdata;
      end
      if (upd_ctrl_q[mptc_pkg::IUE_BIT]) begin
        duty_act_q <= (reg_wr && reg_addr == mptc_pkg::OFS_DUTY_BUF) ? reg_wdata : duty_buf_q; // RULE18
      end else if (!buffer_update_lockout && period_evt) begin
        duty_act_q <= duty_buf_q; // RULE18 RULE20
      end
    end
  end

  // manual override buffer and active override
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovr_buf_q <= mptc_pkg::ZERO16;
      ovr_act_q <= mptc_pkg::ZERO16;
    end else begin
      if (reg_wr && reg_addr == mptc_pkg::OFS_OVR_BUF) begin
        ovr_buf_q <= reg_wdata;
      end
      if (!upd_ctrl_q[mptc_pkg::OVERRIDE_SYNC_SEL_BIT] || bound) begin
        ovr_act_q <= ovr_buf_q; // RULE19
      end
    end
  end

  assign duty_active     = duty_act_q;
  assign override_active = ovr_act_q;
  assign period_active   = per_act_q;

  // ---------------------------------------------------------------
  // postscalers
  // ---------------------------------------------------------------
  // trigger match needs count and direction agreement in up/down
  assign sev_match = tick && (cnt_q == sev_cmp_q) && (!centre || (dir_q == sev_dir_q)); // RULE11 RULE12

  mptc_postscale u_tb_ops (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clr     (1'b0),
    .ratio   (tb_ctrl_q[mptc_pkg::TB_OPS_LSB +: 4]),
    .evt_in  (period_evt),
    .evt_out (tb_event)
  ); // RULE5

  mptc_postscale u_sev_ops (
    .sys_clk (sys_clk),
    .srst    (srst),
    .clr     (sev_wr),
    .ratio   (upd_ctrl_q[mptc_pkg::SEVOPS_LSB +: 4]),
    .evt_in  (sev_match),
    .evt_out (trigger_out)
  ); // RULE17 RULE22

  // ---------------------------------------------------------------
  // register read
  // ---------------------------------------------------------------
  // read mux, unmapped reads zero
  always_comb begin
    unique case (reg_addr)
      mptc_pkg::OFS_TB_CTRL:   rdata_d = tb_ctrl_q;
      mptc_pkg::OFS_TB_COUNT:  rdata_d = {dir_q, cnt_q}; // RULE8 RULE9
      mptc_pkg::OFS_TB_PERIOD: rdata_d = {1'b0, per_buf_q}; // RULE10
      mptc_pkg::OFS_SEV_CMP:   rdata_d = {sev_dir_q, sev_cmp_q};
      mptc_pkg::OFS_PIN_CTRL:  rdata_d = {4'h0, pmod_q, pen_q};
      mptc_pkg::OFS_UPD_CTRL:  rdata_d = upd_ctrl_q;
      mptc_pkg::OFS_DUTY_BUF:  rdata_d = duty_buf_q;
      mptc_pkg::OFS_DUTY_ACT:  rdata_d = duty_act_q;
      mptc_pkg::OFS_OVR_BUF:   rdata_d = ovr_buf_q;
      mptc_pkg::OFS_OVR_ACT:   rdata_d = ovr_act_q;
      mptc_pkg::OFS_PER_ACT:   rdata_d = {1'b0, per_act_q};
      default:                 rdata_d = mptc_pkg::ZERO16;
    endcase
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= mptc_pkg::ZERO16;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= mptc_pkg::ZERO16;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_count_wr;
    cnt_wr && !srst;
  endsequence

  chk_halt_when_off: assert property (@(posedge sys_clk) disable iff (srst) // RULE4
    !tb_ctrl_q[mptc_pkg::TB_EN_BIT] && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved while disabled");
  chk_idle_stop: assert property (@(posedge sys_clk) disable iff (srst) // RULE3
    cpu_idle && tb_ctrl_q[mptc_pkg::TB_IDLE_BIT] && !cnt_wr |=> $stable(cnt_q))
    else $error("counter moved in idle stop");
  chk_dir_read: assert property (@(posedge sys_clk) disable iff (srst) // RULE8
    reg_rd && reg_addr == mptc_pkg::OFS_TB_COUNT |=> reg_rdata[15] == $past(dir_q))
    else $error("direction bit misread");
  chk_count_write: assert property (@(posedge sys_clk) disable iff (srst) // RULE9
    s_count_wr |=> cnt_q == $past(reg_wdata[14:0]))
    else $error("count write lost");
  chk_period_msb: assert property (@(posedge sys_clk) disable iff (srst) // RULE10
    reg_rd && reg_addr == mptc_pkg::OFS_TB_PERIOD |=> !reg_rdata[15])
    else $error("period bit 15 not zero");
  chk_trig_dir: assert property (@(posedge sys_clk) disable iff (srst) // RULE11
    trigger_out && centre |-> dir_q == sev_dir_q)
    else $error("trigger in wrong direction");
  chk_trig_match: assert property (@(posedge sys_clk) disable iff (srst) // RULE12
    trigger_out |-> cnt_q == sev_cmp_q && tick)
    else $error("trigger without match");
  chk_buffer_update_lockout_block: assert property (@(posedge sys_clk) disable iff (srst) // RULE20
    buffer_update_lockout |=> $stable(per_act_q))
    else $error("period moved while locked");
  chk_fault_irq: assert property (@(posedge sys_clk) disable iff (srst) // RULE2
    cpu_sleep && !fault_a_n |-> fault_irq && fault_wake)
    else $error("no fault interrupt in sleep");
  chk_prescale_gap: assert property (@(posedge sys_clk) disable iff (srst) // RULE6
    tick && tb_ctrl_q[3:2] == 2'h1 && tb_run ##1 tb_run[*3] |-> !$past(tick, 1))
    else $error("prescale tick too soon");
  chk_ovr_sync: assert property (@(posedge sys_clk) disable iff (srst) // RULE19
    upd_ctrl_q[mptc_pkg::OVERRIDE_SYNC_SEL_BIT] && !bound |=> $stable(ovr_act_q))
    else $error("override applied off boundary");

endmodule

/* verif/motor_pwm_timebase_control_test.sv */
// testbench: register port sequences against the pwm time base control block
`timescale 1ns/1ps
module motor_pwm_timebase_control_test;
  // ---------------------------------------------------------------
  // signals, tables and bus tasks
  // ---------------------------------------------------------------
  logic        sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        cpu_sleep = 1'b0, cpu_idle = 1'b0, pin_cfg = 1'b1;
  logic [1:0]  fault_cmd = 2'h0;
  logic [3:0]  reg_addr = 4'h0, pair_mode_sel, high_pin_enables, low_pin_enables, stage_driven;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, duty_active, override_active, q;
  logic [14:0] period_active;
  logic        fault_a_n, fault_b_n, fault_wake, fault_irq, tb_event, trigger_out;
  int          k, errors = 0, check_count = 0;
  // reset values, mask writes, event rates and direction expectations
  logic [3:0]  rv_adr [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
  logic [15:0] rv_exp [7] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h00ff, 16'h0, 16'h0};
  logic [3:0]  mk_adr [5] = '{4'h0, 4'h2, 4'h1, 4'h5, 4'hf};
  logic [15:0] mk_wd  [5] = '{16'h5f00, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
  logic [15:0] mk_exp [5] = '{16'h0000, 16'h7fff, 16'h7fff, 16'h0f07, 16'h0000};
  logic [15:0] ev_ctl [6] = '{16'h8000, 16'h8030, 16'h80f0, 16'h8004, 16'h8008, 16'h800c};
  logic [15:0] ev_per [6] = '{16'h2, 16'h2, 16'h2, 16'h2, 16'h1, 16'h1};
  int          ev_win [6] = '{30, 48, 96, 48, 128, 512};
  int          ev_exp [6] = '{10, 4, 2, 4, 4, 4};
  logic [15:0] dr_ctl [3] = '{16'h8004, 16'h8006, 16'h8007};
  logic [15:0] dr_exp [3] = '{16'h0, 16'h1, 16'h1};

  mptc_top i_dut (
    .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_reset_config (pin_cfg), .cpu_sleep, .cpu_idle, .fault_a_n, .fault_b_n,
    .fault_wake, .fault_irq, .tb_event, .trigger_out, .pair_mode_sel,
    .high_pin_enables, .low_pin_enables, .duty_active, .override_active, .period_active
  );
  mptc_power_stage i_stage (
    .fault_cmd, .high_pin_enables, .low_pin_enables, .fault_a_n, .fault_b_n, .stage_driven
  );

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  // compare one value, report a mismatch at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle only
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(posedge sys_clk);
    q = reg_rdata;
  endtask
  // count pulses over n cycles: period event, or trigger when sel is set
  task automatic evt(input int n, input bit sel);
    k = 0;
    repeat (n) begin
      @(posedge sys_clk);
      if ((sel ? trigger_out : tb_event) === 1'b1) k++;
    end
  endtask
  // bounded wait for the next pulse; k holds the cycles spent
  task automatic wait_ev(input bit sel);
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while ((sel ? trigger_out : tb_event) !== 1'b1 && k < 700);
  endtask
  // stop, clear count, load period, then start with the given control word
  task automatic tb_set(input logic [15:0] ctl, input logic [15:0] per);
    wr(mptc_pkg::OFS_TB_CTRL, 16'h0000);
    wr(mptc_pkg::OFS_TB_COUNT, 16'h0000);
    wr(mptc_pkg::OFS_TB_PERIOD, per);
    wr(mptc_pkg::OFS_TB_CTRL, ctl);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under this span
  initial begin
    idle(12000);
    errors++;
    test_done;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    idle(3);
    srst <= 1'b0;
    idle(2);
    for (int i = 0; i < 7; i++) begin
      rd(rv_adr[i]);
      chk(q, rv_exp[i]);
    end
    for (int i = 0; i < 5; i++) begin
      wr(mk_adr[i], mk_wd[i]);
      rd(mk_adr[i]);
      chk(q, mk_exp[i]);
    end
    wr(4'h5, 16'h0000);
    wr(4'h4, 16'h0a5c);
    idle(1);
    chk({4'h0, pair_mode_sel, high_pin_enables, low_pin_enables}, 16'h0a5c);
    chk({12'h000, stage_driven}, 16'h0004);
    // period event rates across postscale and prescale codes
    for (int i = 0; i < 6; i++) begin
      tb_set(ev_ctl[i], ev_per[i]);
      idle(ev_win[i]);
      evt(ev_win[i], 1'b0);
      chk(16'(k), 16'(ev_exp[i]));
    end
    tb_set(16'h0000, 16'h0002);
    evt(50, 1'b0);
    chk(16'(k), 16'h0000);
    rd(4'h1);
    chk(q, 16'h0000);
    cpu_idle <= 1'b1;
    tb_set(16'ha000, 16'h0002);
    evt(30, 1'b0);
    chk(16'(k), 16'h0000);
    wr(4'h0, 16'h8000);
    idle(3);
    evt(30, 1'b0);
    chk(16'(k), 16'h000a);
    cpu_idle <= 1'b0;
    // direction flag and count range per mode
    for (int m = 0; m < 3; m++) begin
      tb_set(dr_ctl[m], 16'h0002);
      k = 0;
      repeat (10) begin
        rd(4'h1);
        if (q[15] === 1'b1) k = k | 1;
        if (q[14:0] > 15'h0002) k = k | 2;
      end
      chk(16'(k), dr_exp[m]);
    end
    tb_set(16'h8001, 16'h0002);
    idle(20);
    rd(4'h1);
    chk(q, 16'h0002);
    // special event trigger, its postscaler and its clear on compare write
    tb_set(16'h8000, 16'h0002);
    wr(4'h3, 16'h0001);
    evt(30, 1'b1);
    chk(16'(k), 16'h000a);
    wr(4'h5, 16'h0100);
    idle(30);
    evt(30, 1'b1);
    chk(16'(k), 16'h0005);
    wr(4'h5, 16'h0f00);
    wait_ev(1'b1);
    idle(30);
    wr(4'h3, 16'h0001);
    wait_ev(1'b1);
    chk(16'(k >= 40 && k <= 50), 16'h0001);
    wr(4'h5, 16'h0000);
    tb_set(16'h8002, 16'h0002);
    wr(4'h3, 16'h8001);
    evt(32, 1'b1);
    chk(16'(k), 16'h0008);
    // update lockout, immediate duty update, period lockout
    wr(4'h5, 16'h0001);
    tb_set(16'h8000, 16'h0002);
    wr(4'h6, 16'h1234);
    wr(4'h2, 16'h0005);
    idle(20);
    rd(4'h7);
    chk(q, 16'h0000);
    wr(4'h5, 16'h0005);
    idle(3);
    rd(4'h7);
    chk(q, 16'h1234);
    chk({1'b0, period_active}, 16'h0002);
    wr(4'h5, 16'h0000);
    idle(20);
    chk({1'b0, period_active}, 16'h0005);
    // duty and override wait for the time base, then immediate override
    tb_set(16'h8000, 16'h0064);
    wr(4'h5, 16'h0002);
    wait_ev(1'b0);
    idle(10);
    wr(4'h6, 16'h00aa);
    wr(4'h8, 16'h005a);
    idle(3);
    rd(4'h7);
    chk(q, 16'h1234);
    rd(4'h9);
    chk(q, 16'h0000);
    idle(100);
    rd(4'h7);
    chk(q, 16'h00aa);
    chk(duty_active, 16'h00aa);
    rd(4'h9);
    chk(q, 16'h005a);
    chk(override_active, 16'h005a);
    wr(4'h5, 16'h0000);
    wr(4'h8, 16'h00a5);
    idle(2);
    rd(4'h9);
    chk(q, 16'h00a5);
    chk(override_active, 16'h00a5);
    // fault pins wake and interrupt only in sleep
    fault_cmd <= 2'h1;
    idle(2);
    chk({14'h0, fault_wake, fault_irq}, 16'h0000);
    cpu_sleep <= 1'b1;
    for (int f = 1; f < 4; f++) begin
      fault_cmd <= 2'(f);
      idle(2);
      chk({14'h0, fault_wake, fault_irq}, 16'h0003);
    end
    fault_cmd <= 2'h0;
    idle(2);
    chk({14'h0, fault_wake, fault_irq}, 16'h0000);
    // second reset with the strap low: pin enables come up clear
    pin_cfg <= 1'b0;
    srst    <= 1'b1;
    idle(3);
    srst    <= 1'b0;
    idle(2);
    rd(mptc_pkg::OFS_PIN_CTRL);
    chk(q, 16'h0000);
    chk({8'h00, high_pin_enables, low_pin_enables}, 16'h0000);
    rd(mptc_pkg::OFS_TB_COUNT);
    chk(q, 16'h0000);
    test_done;
  end
endmodule

/* verif/mptc_power_stage.sv */
// partner: power stage model with fault comparators on the fault lines
`timescale 1ns/1ps
module mptc_power_stage (
  input  wire logic [1:0] fault_cmd,
  input  wire logic [3:0] high_pin_enables,
  input  wire logic [3:0] low_pin_enables,
  output logic            fault_a_n,
  output logic            fault_b_n,
  output logic [3:0]      stage_driven
);
  // open-drain fault lines with pull-ups: high unless a comparator trips
  assign fault_a_n = ~fault_cmd[0];
  assign fault_b_n = ~fault_cmd[1];
  // a leg switches only while both its gate pins carry pwm, else its gates float off
  assign stage_driven = high_pin_enables & low_pin_enables;
endmodule
